// ---- verilog/fetc_top.sv ----
// FIFO event-clear, flush and transmit FIFO control for a serial channel.
//
// Contract
// [R1] Writing one to bit 0 clears the standard receive event flag.
// [R2] Writing one to bit 1 clears the receive error event flag.
// [R3] Writing one to bit 2 clears the alternative receive event flag.
// [R4] Writing one to bit 8 clears the standard transmit event flag.
// [R5] Writing one to bit 9 clears the transmit error event flag.
// [R6] Writing one to bit 10 clears the bypass word valid flag.
// [R7] Bit 14 flushes the receive FIFO: level zero, output pointer to input.
// [R8] Bit 15 flushes the transmit FIFO: level zero, output pointer to input.
// [R9] Software flushes a FIFO only while it carries no traffic.
// [R10] Unused clear register bits read zero; software writes them zero.
// [R11] Transmit control writes are dropped unless the transmit function is enabled.
// [R12] Pointer start field bits 5..0 is write only and reads zero.
// [R13] Start write with size zero loads both pointers and empties the buffer.
// [R14] Start write with nonzero size is ignored.
// [R15] Limit field bits 13..8 holds the standard transmit event level.
// [R16] Trigger mode zero: trigger raises events; cleared when level equals limit.
// [R17] Trigger mode one: same events; cleared when level equals buffer size.
// [R18] Bit 15 enables events through the software trigger flag.
// [R19] Every read of the clear register returns zero.
// [R20] Overflow select picks downward on transmit or upward on write.
// [R21] Size code zero disables the transmit FIFO; no data accepted.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "fetc_params.svh"
module fetc_top
  import fetc_pkg::*;
(
  // Clock and reset.
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Register port.
  input  wire logic [`FETC_ADDR_W-1:0] addr,
  input  wire logic [31:0]             wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic      [31:0]             rdata,
  // Channel configuration.
  input  wire logic                    tx_fifo_function_enable,
  // Event sources from the channel.
  input  wire logic                    std_rx_event,
  input  wire logic                    rx_error_event,
  input  wire logic                    alt_rx_event,
  input  wire logic                    bypass_word_load,
  // Transmit data path.
  input  wire logic                    tx_data_write,
  input  wire logic                    tx_word_transfer,
  // Flags.
  output logic                         std_rx_event_flag,
  output logic                         rx_error_event_flag,
  output logic                         alt_rx_event_flag,
  output logic                         std_tx_event_flag,
  output logic                         tx_error_event_flag,
  output logic                         bypass_word_valid,
  output logic                         sw_trigger_flag,
  // Receive FIFO flush request.
  output logic                         rx_fifo_flush,
  // Transmit FIFO state.
  output logic      [5:0]              tx_input_pointer,
  output logic      [5:0]              tx_output_pointer,
  output logic      [6:0]              tx_fill_level
);

  fetc_ptr_if    pif ();
  fetc_tx_ctrl_t transmit_fifo_control;
  logic          wr_clear;
  logic          wr_ctrl;
  logic          wr_status;
  logic          ctrl_ok;
  logic          tx_fifo_flush;
  logic          push_ok;
  logic          pop_ok;
  logic          limit_event;
  logic          trig_event;
  logic          trig_done;
  logic [6:0]    entries;
  logic [5:0]    flag_set;
  logic [5:0]    flag_clr;
  logic [5:0]    flag_q;
  logic [31:0]   next_rdata;

  // Address decode of the three registers.
  assign wr_clear  = wr && (addr == `FETC_OFS_EVENT_CLEAR);
  assign wr_ctrl   = wr && (addr == `FETC_OFS_TX_CTRL);
  assign wr_status = wr && (addr == `FETC_OFS_STATUS);
  assign ctrl_ok   = wr_ctrl && tx_fifo_function_enable; // [R11]

  // Transmit control fields. The pointer start field is not stored.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      transmit_fifo_control <= fetc_tx_ctrl_t'(`FETC_CTRL_RESET);
    else if (ctrl_ok)
    begin
      transmit_fifo_control.limit     <= wdata[`FETC_CTL_LIMIT_MSB:`FETC_CTL_LIMIT_LSB]; // [R15]
      transmit_fifo_control.trig_mode <= wdata[`FETC_CTL_TRIG_MODE];
      transmit_fifo_control.trig_en   <= wdata[`FETC_CTL_TRIG_EN]; // [R18]
      transmit_fifo_control.size      <= wdata[`FETC_CTL_SIZE_MSB:`FETC_CTL_SIZE_LSB];
      transmit_fifo_control.overflow_direction_select       <= wdata[`FETC_CTL_LOF];
    end
  end

  // Pointer keeper controls.
  assign entries = (transmit_fifo_control.size > `FETC_SIZE_MAX) ? 7'h40
                 : (7'h01 << transmit_fifo_control.size);
  assign tx_fifo_flush = wr_clear && wdata[`FETC_CLR_TX_FLUSH]; // [R8]
  // Size zero keeps the FIFO shut, so writes are not taken at all.
  assign push_ok = tx_data_write && (transmit_fifo_control.size != `FETC_SIZE_OFF); // [R21]
  assign pop_ok  = tx_word_transfer && (pif.level != 7'h00);

  assign pif.push  = push_ok;
  assign pif.pop   = tx_word_transfer;
  assign pif.flush = tx_fifo_flush;
  // The load only goes through while the buffer has no entries assigned.
  assign pif.load  = ctrl_ok && (transmit_fifo_control.size == `FETC_SIZE_OFF); // [R13] [R14]
  assign pif.load_val = wdata[`FETC_CTL_PTR_MSB:`FETC_CTL_PTR_LSB];
  assign pif.size  = transmit_fifo_control.size;

  fetc_tx_ptr u_tx_ptr
  (
    .clk   (clk),
    .rst_n (rst_n),
    .pif   (pif.keep)
  );

  // Limit crossing: level sits at the limit and moves in the chosen direction.
  always_comb
  begin
    limit_event = 1'b0;
    if (transmit_fifo_control.overflow_direction_select)
      limit_event = push_ok && !pif.full && !pop_ok
                  && (pif.level == {1'b0, transmit_fifo_control.limit}); // [R20]
    else
      limit_event = pop_ok && !push_ok
                  && (pif.level == {1'b0, transmit_fifo_control.limit}); // [R20]
  end

  // Trigger events follow the same direction choice as the limit event.
  assign trig_event = sw_trigger_flag && transmit_fifo_control.trig_en
                    && (transmit_fifo_control.overflow_direction_select ? push_ok : pop_ok); // [R16] [R17] [R18]

  // Trigger finishes at the limit in mode zero, at the full size in mode one.
  assign trig_done = transmit_fifo_control.trig_mode
                   ? (pif.level == entries) // [R17]
                   : (pif.level == {1'b0, transmit_fifo_control.limit}); // [R16]

  // Software trigger flag; a set by software wins over the hardware clear.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_trigger_flag <= 1'b0;
    else if (wr_status && wdata[`FETC_STS_TRIG_SET])
      sw_trigger_flag <= 1'b1;
    else if (trig_done)
      sw_trigger_flag <= 1'b0; // [R16] [R17]
  end

  // Flag set sources, one per flag index.
  always_comb
  begin
    flag_set = 6'h00;
    flag_set[FETC_F_STD_RX] = std_rx_event;
    flag_set[FETC_F_RX_ERR] = rx_error_event;
    flag_set[FETC_F_ALT_RX] = alt_rx_event;
    flag_set[FETC_F_STD_TX] = limit_event || trig_event;
    // Writing a full buffer with no word transfer in the same cycle is the transmit error.
    flag_set[FETC_F_TX_ERR] = push_ok && pif.full && !pop_ok;
    flag_set[FETC_F_BYPASS] = bypass_word_load;
  end

  // Clear strobes; zero bits leave their flags alone.
  always_comb
  begin
    flag_clr = 6'h00;
    flag_clr[FETC_F_STD_RX] = wr_clear && wdata[`FETC_CLR_STD_RX]; // [R1]
    flag_clr[FETC_F_RX_ERR] = wr_clear && wdata[`FETC_CLR_RX_ERR]; // [R2]
    flag_clr[FETC_F_ALT_RX] = wr_clear && wdata[`FETC_CLR_ALT_RX]; // [R3]
    flag_clr[FETC_F_STD_TX] = wr_clear && wdata[`FETC_CLR_STD_TX]; // [R4]
    flag_clr[FETC_F_TX_ERR] = wr_clear && wdata[`FETC_CLR_TX_ERR]; // [R5]
    flag_clr[FETC_F_BYPASS] = wr_clear && wdata[`FETC_CLR_BYPASS]; // [R6]
  end

  // One sticky flag per event.
  for (genvar i = 0; i < 6; i++)
  begin : g_flag
    fetc_flag u_flag
    (
      .clk   (clk),
      .rst_n (rst_n),
      .set   (flag_set[i]),
      .clr   (flag_clr[i]),
      .flag  (flag_q[i])
    );
  end

  assign std_rx_event_flag   = flag_q[FETC_F_STD_RX];
  assign rx_error_event_flag = flag_q[FETC_F_RX_ERR];
  assign alt_rx_event_flag   = flag_q[FETC_F_ALT_RX];
  assign std_tx_event_flag   = flag_q[FETC_F_STD_TX];
  assign tx_error_event_flag = flag_q[FETC_F_TX_ERR];
  assign bypass_word_valid   = flag_q[FETC_F_BYPASS];

  // Receive flush is a one-cycle pulse to the receive FIFO keeper.
  // Flushing during traffic may drop a word in flight; software avoids that.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_fifo_flush <= 1'b0;
    else
      rx_fifo_flush <= wr_clear && wdata[`FETC_CLR_RX_FLUSH]; // [R7] [R9]
  end

  // Transmit state mirrors are straight from the keeper's flip-flops.
  assign tx_input_pointer  = pif.in_ptr;
  assign tx_output_pointer = pif.out_ptr;
  assign tx_fill_level     = pif.level;

  // Read mux; unmapped addresses and the clear register read zero.
  always_comb
  begin
    next_rdata = `FETC_ZERO32;
    case (addr)
      `FETC_OFS_EVENT_CLEAR: next_rdata = `FETC_ZERO32; // [R10] [R19]
      `FETC_OFS_TX_CTRL:
      begin
        // Pointer start bits stay zero on read.
        next_rdata[`FETC_CTL_LIMIT_MSB:`FETC_CTL_LIMIT_LSB] = transmit_fifo_control.limit; // [R12]
        next_rdata[`FETC_CTL_TRIG_MODE] = transmit_fifo_control.trig_mode;
        next_rdata[`FETC_CTL_TRIG_EN]   = transmit_fifo_control.trig_en;
        next_rdata[`FETC_CTL_SIZE_MSB:`FETC_CTL_SIZE_LSB] = transmit_fifo_control.size;
        next_rdata[`FETC_CTL_LOF]       = transmit_fifo_control.overflow_direction_select;
      end
      `FETC_OFS_STATUS:
      begin
        next_rdata[`FETC_CLR_STD_RX] = flag_q[FETC_F_STD_RX];
        next_rdata[`FETC_CLR_RX_ERR] = flag_q[FETC_F_RX_ERR];
        next_rdata[`FETC_CLR_ALT_RX] = flag_q[FETC_F_ALT_RX];
        next_rdata[`FETC_CLR_STD_TX] = flag_q[FETC_F_STD_TX];
        next_rdata[`FETC_CLR_TX_ERR] = flag_q[FETC_F_TX_ERR];
        next_rdata[`FETC_CLR_BYPASS] = flag_q[FETC_F_BYPASS];
        next_rdata[`FETC_STS_TRIG_SET] = sw_trigger_flag;
        next_rdata[`FETC_STS_LEVEL_LSB +: 7] = pif.level;
      end
      default: next_rdata = `FETC_ZERO32;
    endcase
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= `FETC_ZERO32;
    else if (rd)
      rdata <= next_rdata;
    else
      rdata <= `FETC_ZERO32;
  end

endmodule

// ---- common/fetc_params.svh ----
// Register offsets, field positions and reset values of the FIFO event-clear block.
`ifndef FETC_PARAMS_SVH
`define FETC_PARAMS_SVH

`define FETC_ADDR_W            8
`define FETC_OFS_EVENT_CLEAR   8'h00
`define FETC_OFS_TX_CTRL       8'h04
`define FETC_OFS_STATUS        8'h08

`define FETC_CLR_STD_RX        0
`define FETC_CLR_RX_ERR        1
`define FETC_CLR_ALT_RX        2
`define FETC_CLR_STD_TX        8
`define FETC_CLR_TX_ERR        9
`define FETC_CLR_BYPASS        10
`define FETC_CLR_RX_FLUSH      14
`define FETC_CLR_TX_FLUSH      15

`define FETC_CTL_PTR_LSB       0
`define FETC_CTL_PTR_MSB       5
`define FETC_CTL_LIMIT_LSB     8
`define FETC_CTL_LIMIT_MSB     13
`define FETC_CTL_TRIG_MODE     14
`define FETC_CTL_TRIG_EN       15
`define FETC_CTL_SIZE_LSB      24
`define FETC_CTL_SIZE_MSB      26
`define FETC_CTL_LOF           28
`define FETC_CTL_RMASK         32'h170_0ff00

`define FETC_STS_TRIG_SET      14
`define FETC_STS_LEVEL_LSB     24

`define FETC_SIZE_OFF          3'h0
`define FETC_SIZE_MAX          3'h6
`define FETC_CTRL_RESET        32'h0000_0000
`define FETC_ZERO32            32'h0000_0000

`endif

// ---- common/fetc_pkg.sv ----
// Types shared by the FIFO event-clear block modules.
package fetc_pkg;

  // Indices of the sticky event flags.
  typedef enum logic [2:0]
  {
    FETC_F_STD_RX = 3'b000,
    FETC_F_RX_ERR = 3'b001,
    FETC_F_ALT_RX = 3'b010,
    FETC_F_STD_TX = 3'b011,
    FETC_F_TX_ERR = 3'b100,
    FETC_F_BYPASS = 3'b101
  } fetc_flag_t;

  // Held fields of the transmit FIFO control register.
  typedef struct packed
  {
    logic       overflow_direction_select;
    logic [2:0] size;
    logic       trig_en;
    logic       trig_mode;
    logic [5:0] limit;
  } fetc_tx_ctrl_t;

endpackage

// ---- common/fetc_ptr_if.sv ----
// Carrier between the control logic and the transmit pointer keeper.
`timescale 1ns/10ps
interface fetc_ptr_if;
  logic       push;
  logic       pop;
  logic       flush;
  logic       load;
  logic [5:0] load_val;
  logic [2:0] size;
  logic [5:0] in_ptr;
  logic [5:0] out_ptr;
  logic [6:0] level;
  logic       full;

  modport ctrl (output push, pop, flush, load, load_val, size,
                input in_ptr, out_ptr, level, full);
  modport keep (input push, pop, flush, load, load_val, size,
                output in_ptr, out_ptr, level, full);
endinterface

// ---- verilog/fetc_flag.sv ----
// One sticky event flag: hardware set wins over a software clear.
`timescale 1ns/10ps
module fetc_flag
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Set and clear strobes.
  input  wire logic set,
  input  wire logic clr,
  // Flag state.
  output logic      flag
);

  // A set in the clearing cycle survives, so no event is lost.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag <= 1'b0;
    else if (set)
      flag <= 1'b1;
    else if (clr)
      flag <= 1'b0;
  end

endmodule

// ---- verilog/fetc_tx_ptr.sv ----
// Transmit FIFO pointers and filling level.
`timescale 1ns/10ps
`include "fetc_params.svh"
module fetc_tx_ptr
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst_n,
  // Control side.
  fetc_ptr_if.keep  pif
);

  logic [5:0] base;
  logic [6:0] entries;
  logic [5:0] next_in;
  logic [5:0] next_out;
  logic       do_push;
  logic       do_pop;

  // Codes above the largest size are clamped to it.
  assign entries = (pif.size > `FETC_SIZE_MAX) ? 7'h40 : (7'h01 << pif.size);
  assign pif.full = (pif.level == entries);
  assign do_push = pif.push && (pif.size != `FETC_SIZE_OFF) && !pif.full;
  assign do_pop  = pif.pop && (pif.level != 7'h00);

  // Pointers wrap inside the region that starts at the loaded base.
  // The offset is kept to six bits, so a region that runs past the top
  // of the pointer space still measures its distance from the base right.
  assign next_in  = (({1'b0, 6'(pif.in_ptr - base)} + 7'h01) == entries)
                  ? base : pif.in_ptr + 6'h01;
  assign next_out = (({1'b0, 6'(pif.out_ptr - base)} + 7'h01) == entries)
                  ? base : pif.out_ptr + 6'h01;

  // Base value, updated only by an accepted start-value load.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      base <= 6'h00;
    else if (pif.load)
      base <= pif.load_val;
  end

  // Input pointer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pif.in_ptr <= 6'h00;
    else if (pif.load)
      pif.in_ptr <= pif.load_val;
    else if (do_push)
      pif.in_ptr <= next_in;
  end

  // Output pointer; a flush snaps it onto the input pointer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pif.out_ptr <= 6'h00;
    else if (pif.load)
      pif.out_ptr <= pif.load_val;
    else if (pif.flush)
      pif.out_ptr <= do_push ? next_in : pif.in_ptr;
    else if (do_pop)
      pif.out_ptr <= next_out;
  end

  // Filling level; a flush empties the buffer, dropping a word written alongside too.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pif.level <= 7'h00;
    else if (pif.load || pif.flush)
      pif.level <= 7'h00;
    else if (do_push && !do_pop)
      pif.level <= pif.level + 7'h01;
    else if (do_pop && !do_push)
      pif.level <= pif.level - 7'h01;
  end

endmodule

// ---- dv/fetc_top_properties.sv ----
// Port-level concurrent checks for the FIFO event-clear block.
`timescale 1ns/10ps
`include "fetc_params.svh"
module fetc_top_properties
(
  // Clock, reset and register port.
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire logic [`FETC_ADDR_W-1:0] addr,
  input wire logic [31:0]             wdata,
  input wire logic                    wr,
  input wire logic                    rd,
  input wire logic [31:0]             rdata,
  // Sources from the channel.
  input wire logic                    std_rx_event,
  input wire logic                    bypass_word_load,
  input wire logic                    tx_data_write,
  input wire logic                    tx_word_transfer,
  // Results.
  input wire logic                    std_rx_event_flag,
  input wire logic                    rx_error_event_flag,
  input wire logic                    std_tx_event_flag,
  input wire logic                    bypass_word_valid,
  input wire logic                    rx_fifo_flush,
  input wire logic [5:0]              tx_input_pointer,
  input wire logic [5:0]              tx_output_pointer,
  input wire logic [6:0]              tx_fill_level
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A clear-register write with one chosen bit set.
  sequence clr_wr(int b);
    wr && addr == `FETC_OFS_EVENT_CLEAR && wdata[b];
  endsequence

  // A read of one register, answered in the next cycle.
  sequence rd_of(logic [7:0] a);
    rd && addr == a;
  endsequence

  // A set pulse in the clear cycle would win, so those cycles are left out.
  rx_std_clear_a: assert property (clr_wr(0) ##0 !std_rx_event |=> !std_rx_event_flag)
    else $error("standard receive flag not cleared");
  rx_err_hold_a: assert property (wr && addr == 8'h00 && !wdata[1] && rx_error_event_flag
    |=> rx_error_event_flag) else $error("receive error flag lost on zero write");
  tx_std_clear_a: assert property (clr_wr(8) ##0 !(tx_data_write || tx_word_transfer)
    |=> !std_tx_event_flag) else $error("standard transmit flag not cleared");
  bypass_clear_a: assert property (clr_wr(10) ##0 !bypass_word_load
    |=> !bypass_word_valid) else $error("bypass valid not cleared");
  rx_flush_pulse_a: assert property (clr_wr(14) |=> rx_fifo_flush)
    else $error("receive flush missing");
  rx_flush_only_a: assert property (!(wr && addr == 8'h00 && wdata[14]) |=> !rx_fifo_flush)
    else $error("receive flush without request");
  tx_flush_a: assert property (clr_wr(15) ##0 !tx_data_write |=> tx_fill_level == 7'h00
    && tx_output_pointer == $past(tx_input_pointer)) else $error("transmit flush wrong");
  clr_read_zero_a: assert property (rd_of(8'h00) |=> rdata == 32'h0000_0000)
    else $error("clear register read not zero");
  ptr_read_zero_a: assert property (rd_of(8'h04) |=> rdata[5:0] == 6'h00)
    else $error("pointer field read not zero");
endmodule

bind fetc_top fetc_top_properties fetc_top_properties_inst (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .std_rx_event(std_rx_event),
  .bypass_word_load(bypass_word_load), .tx_data_write(tx_data_write),
  .tx_word_transfer(tx_word_transfer), .std_rx_event_flag(std_rx_event_flag),
  .rx_error_event_flag(rx_error_event_flag), .std_tx_event_flag(std_tx_event_flag),
  .bypass_word_valid(bypass_word_valid), .rx_fifo_flush(rx_fifo_flush),
  .tx_input_pointer(tx_input_pointer), .tx_output_pointer(tx_output_pointer),
  .tx_fill_level(tx_fill_level));

// ---- dv/fetc_chan_model.sv ----
// Channel-side model: event sources and transmit data pulses.
`timescale 1ns/10ps
module fetc_chan_model
(
  // Clock.
  input  wire logic clk,
  // Pulses toward the block.
  output logic      std_rx_event,
  output logic      rx_error_event,
  output logic      alt_rx_event,
  output logic      bypass_word_load,
  output logic      tx_data_write,
  output logic      tx_word_transfer
);
  logic [5:0] pend = 6'h00;

  // One bit per source; several may fire in the same cycle.
  assign {tx_word_transfer, tx_data_write, bypass_word_load} = pend[5:3];
  assign {alt_rx_event, rx_error_event, std_rx_event} = pend[2:0];

  // Raises the chosen sources for one cycle; a gap models a slow channel.
  task automatic fire(input logic [5:0] m, input int gap);
    @(posedge clk);
    pend <= m;
    @(posedge clk);
    pend <= 6'h00;
    repeat (gap) @(posedge clk);
    #1;
  endtask
endmodule

// ---- dv/tb_fetc_top.sv ----
// Self-checking bench for the FIFO event-clear block.
`timescale 1ns/10ps
`include "fetc_params.svh"
module tb_fetc_top;
  import fetc_pkg::*;
  logic                    clk, rst_n, wr, rd, en;
  logic [`FETC_ADDR_W-1:0] addr;
  logic [31:0]             wdata, rdata, d;
  logic                    s_rx, s_re, s_alt, s_byp, s_wr, s_xf;
  logic                    f_rx, f_re, f_alt, f_tx, f_te, f_byp, f_trig;
  logic [5:0]              in_p, out_p, p, ef;
  logic [6:0]              lvl;
  int                      err_total, comparisons;
  wire  [5:0]              flags = {f_byp, f_te, f_tx, f_alt, f_re, f_rx};

  fetc_top fetc_top_inst (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .tx_fifo_function_enable(en), .std_rx_event(s_rx),
    .rx_error_event(s_re), .alt_rx_event(s_alt), .bypass_word_load(s_byp),
    .tx_data_write(s_wr), .tx_word_transfer(s_xf), .std_rx_event_flag(f_rx),
    .rx_error_event_flag(f_re), .alt_rx_event_flag(f_alt), .std_tx_event_flag(f_tx),
    .tx_error_event_flag(f_te), .bypass_word_valid(f_byp), .sw_trigger_flag(f_trig),
    .rx_fifo_flush(), .tx_input_pointer(in_p), .tx_output_pointer(out_p),
    .tx_fill_level(lvl));
  fetc_chan_model fetc_chan_model_inst (.clk(clk), .std_rx_event(s_rx),
    .rx_error_event(s_re), .alt_rx_event(s_alt), .bypass_word_load(s_byp),
    .tx_data_write(s_wr), .tx_word_transfer(s_xf));

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  // Flags left standing after a clear write.
  function automatic logic [5:0] after_clear(logic [5:0] f, logic [31:0] w);
    return f & ~{w[10], w[9], w[8], w[2], w[1], w[0]};
  endfunction

  // Entries of a transmit buffer with a given size code.
  function automatic logic [6:0] cap(logic [2:0] s);
    return 7'h01 << s;
  endfunction

  // Word and flag comparisons; both count and report.
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_f(input logic [5:0] got, input logic [5:0] exp);
    chk_w({26'h0, got}, {26'h0, exp});
  endtask

  // Register port cycles; read data stand only in the cycle after the strobe.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic report_and_stop;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // Main sequence: transmit buffer first, then random clear traffic.
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {wr, rd, en, addr, wdata} = '0;
    void'($urandom(62));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk_w({in_p, out_p, lvl, flags}, 32'h0);
    wr_reg(8'h04, 32'h0100_0000);
    fetc_chan_model_inst.fire(6'h10, 0);
    chk_w(lvl, 32'h0);
    @(posedge clk) en <= 1'b1;
    p = $urandom;
    wr_reg(8'h04, {26'h0, p});
    chk_w({in_p, out_p}, {20'h0, p, p});
    wr_reg(8'h04, 32'h1100_0100 | p);
    wr_reg(8'h04, 32'h1100_0100 | (p ^ 6'h15));
    chk_w({in_p, out_p}, {20'h0, p, p});
    rd_reg(8'h04, d);
    chk_w(d, 32'h1100_0100);
    fetc_chan_model_inst.fire(6'h10, 0);
    chk_f(flags, 6'h00);
    fetc_chan_model_inst.fire(6'h10, 2);
    chk_f(flags, 6'h08);
    fetc_chan_model_inst.fire(6'h10, 0);
    chk_w({lvl, flags}, {19'h0, cap(3'h1), 6'h18});
    wr_reg(8'h00, 32'h0000_0300);
    chk_f(flags, 6'h00);
    wr_reg(8'h04, 32'h0100_0100);
    fetc_chan_model_inst.fire(6'h20, 0);
    chk_f(flags, 6'h00);
    fetc_chan_model_inst.fire(6'h20, 0);
    chk_w({lvl, flags}, 32'h08);
    fetc_chan_model_inst.fire(6'h10, 0);
    fetc_chan_model_inst.fire(6'h10, 0);
    wr_reg(8'h00, 32'h0000_8100);
    chk_w({lvl, out_p, f_tx}, {19'h0, in_p, 1'b0});
    for (int m = 0; m < 2; m++)
    begin
      wr_reg(8'h04, 32'h1200_8200 | (m << 14));
      wr_reg(8'h08, 32'h0000_4000);
      fetc_chan_model_inst.fire(6'h10, 0);
      chk_w({f_trig, f_tx}, 32'h3);
      wr_reg(8'h00, 32'h0000_0100);
      fetc_chan_model_inst.fire(6'h10, 1);
      chk_w({f_trig, f_tx}, {30'h0, m[0], 1'b1});
      wr_reg(8'h00, 32'h0000_8100);
    end
    wr_reg(8'h04, 32'h1200_4200);
    fetc_chan_model_inst.fire(6'h10, 0);
    chk_w({f_trig, f_tx}, 32'h2);
    wr_reg(8'h00, 32'h0000_8000);
    fetc_chan_model_inst.fire(6'h0f, 0);
    ef = 6'h27;
    wr_reg(8'h00, 32'h0);
    chk_f(flags, ef);
    rd_reg(8'h08, d);
    chk_w(d, 32'h0000_4407);
    for (int i = 0; i < 12; i++)
    begin
      d = $urandom & 32'h0000_c707;
      wr_reg(8'h00, d);
      ef = after_clear(ef, d);
      chk_f(flags, ef);
      rd_reg(8'h00, d);
      chk_w(d, 32'h0);
      fetc_chan_model_inst.fire(6'h0f, 0);
      ef = ef | 6'h27;
    end
    report_and_stop();
  end
endmodule
